// [hdl/tcc_config_control.v]
`timescale 1ns/1ps
`include "tcc_regs.vh"
module tcc_config_control #(
  parameter RES_W = 24,
  parameter N_RES = 13
) (
  // Clock and reset.
  input  wire                   clk_in,
  input  wire                   sys_rst_in,
  // Register access from the serial front end.
  input  wire                   wr_en_in,
  input  wire [5:0]             addr_in,
  input  wire [7:0]             wdata_in,
  output reg  [7:0]             rdata_out,
  // Measurement pins.
  input  wire                   start_pin_in,
  input  wire                   stop_pin_in,
  output reg                    launch_pulse_out,
  // Measurement core handshake.
  input  wire                   meas_done_in,
  input  wire                   meas_abort_in,
  input  wire                   cal_done_in,
  input  wire [N_RES*RES_W-1:0] raw_result_in,
  input  wire                   raw_valid_in,
  output reg                    start_event_out,
  output reg                    stop_event_out,
  output reg                    cal_run_out,
  output reg                    status_clear_out,
  output reg  [1:0]             timing_range_select_out,
  output reg  [5:0]             second_cal_span_out,
  output reg  [7:0]             averaging_count_out,
  output reg  [2:0]             stop_count_out,
  output reg                    busy_out,
  output reg  [N_RES*RES_W-1:0] result_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers and measurement state.
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_CAL  = 2'h2;

  reg [7:0]             config_first;
  reg [7:0]             config_second;
  reg [1:0]             state;
  reg [3:0]             launch_cnt;
  reg                   start_q;
  reg                   stop_q;
  reg [N_RES*RES_W-1:0] result_raw;
  wire [N_RES*RES_W-1:0] result_par;
  wire                  begin_wr;
  wire                  parity_en;
  wire                  launch_pol;

  assign begin_wr = wr_en_in && addr_in == `TCC_ADDR_CONFIG_FIRST &&
                    wdata_in[`TCC_BIT_BEGIN];
  assign parity_en = config_first[`TCC_BIT_PARITY_EN];
  // A write to the first config register moves the idle level at once, so a
  // launch that also flips the polarity still shows a clean leading edge.
  assign launch_pol = (wr_en_in && addr_in == `TCC_ADDR_CONFIG_FIRST) ?
                      wdata_in[`TCC_BIT_LAUNCH_POL] :
                      config_first[`TCC_BIT_LAUNCH_POL];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and the self-clearing begin bit.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      config_first  <= `TCC_RST_CONFIG_FIRST;
      config_second <= `TCC_RST_CONFIG_SECOND;
    end else begin
      if (wr_en_in && addr_in == `TCC_ADDR_CONFIG_FIRST) begin
        // A written 0 in the begin bit never cancels a running measurement.
        config_first <= {wdata_in[7:1],
                         wdata_in[`TCC_BIT_BEGIN] |
                         (config_first[`TCC_BIT_BEGIN] &&
                          state != ST_IDLE)};
      end else if (state == ST_IDLE && launch_cnt == 4'h0) begin
        config_first[`TCC_BIT_BEGIN] <= 1'b0;
      end
      if (wr_en_in && addr_in == `TCC_ADDR_CONFIG_SECOND) begin
        config_second <= wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run sequencer: launch, wait for end, optional calibration.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state            <= ST_IDLE;
      launch_cnt       <= 4'h0;
      cal_run_out      <= 1'b0;
      status_clear_out <= 1'b0;
      busy_out         <= 1'b0;
    end else begin
      status_clear_out <= begin_wr;
      if (launch_cnt != 4'h0) begin
        launch_cnt <= launch_cnt - 4'h1;
      end
      case (state)
        ST_IDLE: begin
          if (begin_wr) begin
            state      <= ST_RUN;
            launch_cnt <= `TCC_LAUNCH_CYCLES;
            busy_out   <= 1'b1;
          end
        end
        ST_RUN: begin
          if (meas_done_in) begin
            state       <= ST_CAL;
            cal_run_out <= 1'b1;
          end else if (meas_abort_in) begin
            if (config_first[`TCC_BIT_FORCE_CAL]) begin
              state       <= ST_CAL;
              cal_run_out <= 1'b1;
            end else begin
              state    <= ST_IDLE;
              busy_out <= 1'b0;
            end
          end
        end
        ST_CAL: begin
          cal_run_out <= 1'b0;
          if (cal_done_in) begin
            state    <= ST_IDLE;
            busy_out <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch pulse with selectable polarity.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      launch_pulse_out <= 1'b0;
    end else begin
      launch_pulse_out <= (launch_cnt != 4'h0) ^ launch_pol;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop edge detection on the selected edges.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      start_q         <= 1'b0;
      stop_q          <= 1'b0;
      start_event_out <= 1'b0;
      stop_event_out  <= 1'b0;
    end else begin
      start_q <= start_pin_in;
      stop_q  <= stop_pin_in;
      start_event_out <= state == ST_RUN &&
        (config_first[`TCC_BIT_START_EDGE] ? (start_q && !start_pin_in)
                                           : (!start_q && start_pin_in));
      stop_event_out <= state == ST_RUN &&
        (config_first[`TCC_BIT_STOP_EDGE] ? (stop_q && !stop_pin_in)
                                          : (!stop_q && stop_pin_in));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration fields for the core.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      timing_range_select_out <= `TCC_RANGE_SHORT;
      second_cal_span_out     <= `TCC_SPAN_1;
      averaging_count_out     <= 8'h01;
      stop_count_out          <= `TCC_STOPS_ONE;
    end else begin
      // Reserved range codes fall back to the short range.
      timing_range_select_out <=
        (config_first[`TCC_RANGE_HI:`TCC_RANGE_LO] == `TCC_RANGE_LONG) ?
        `TCC_RANGE_LONG : `TCC_RANGE_SHORT;
      case (config_second[`TCC_SPAN_HI:`TCC_SPAN_LO])
        2'h0:    second_cal_span_out <= `TCC_SPAN_0;
        2'h1:    second_cal_span_out <= `TCC_SPAN_1;
        2'h2:    second_cal_span_out <= `TCC_SPAN_2;
        default: second_cal_span_out <= `TCC_SPAN_3;
      endcase
      averaging_count_out <=
        8'h01 << config_second[`TCC_AVG_HI:`TCC_AVG_LO];
      if (config_second[`TCC_STOPS_HI:`TCC_STOPS_LO] > `TCC_STOPS_MAX_CODE)
        stop_count_out <= `TCC_STOPS_ONE;
      else
        stop_count_out <= config_second[`TCC_STOPS_HI:`TCC_STOPS_LO] +
                          `TCC_STOPS_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture, cleared on each new run, with parity per word.
  always @(posedge clk_in) begin
    if (sys_rst_in || begin_wr) begin
      result_raw <= {N_RES*RES_W{1'b0}};
    end else if (raw_valid_in) begin
      result_raw <= raw_result_in;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_RES; gi = gi + 1) begin : g_par
      tcc_parity #(.W(RES_W)) u_par (
        .data_in   (result_raw[gi*RES_W +: RES_W]),
        .enable_in (parity_en),
        .data_out  (result_par[gi*RES_W +: RES_W])
      );
    end
  endgenerate

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      result_out <= {N_RES*RES_W{1'b0}};
    end else begin
      result_out <= result_par;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read data.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      case (addr_in)
        `TCC_ADDR_CONFIG_FIRST:  rdata_out <= config_first;
        `TCC_ADDR_CONFIG_SECOND: rdata_out <= config_second;
        default:                 rdata_out <= 8'h00;
      endcase
    end
  end
endmodule

// [hdl/tcc_regs.vh]
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
// Behaviour
// - With forced calibration off, calibrate after each normal end only.
// - With forced calibration on, calibrate after every attempt.
// - Parity enable (bit 6) clear holds each result parity bit at zero.
// - Parity enable set makes each result word even parity.
// - Launch pulse is a rising edge with bit 5 low, falling with it high.
// - Stop edge bit 4 picks the stop input edge that ends an interval.
// - Start edge bit 3 picks the start input edge that begins one.
// - Range code 00 is the short range, 01 the long; 10 and 11 reserved.
// - The begin bit (bit 0) clears itself when the run completes.
// - Writing 1 to the begin bit clears status and zeroes results; it launches only when idle.
// - Second config register at 01h resets to 40h with three fields.
// - Second calibration span is 2, 10, 20 or 40 clock periods.
// - Averaging field selects 1 to 128 cycles as a power of two.
// - Stop field selects one to five stops; codes above 100 mean one.

// Register addresses.
`define TCC_ADDR_CONFIG_FIRST  6'h00
`define TCC_ADDR_CONFIG_SECOND 6'h01

// Reset values.
`define TCC_RST_CONFIG_FIRST   8'h00
`define TCC_RST_CONFIG_SECOND  8'h40

// Field positions in the first config register.
`define TCC_BIT_FORCE_CAL      7
`define TCC_BIT_PARITY_EN      6
`define TCC_BIT_LAUNCH_POL     5
`define TCC_BIT_STOP_EDGE      4
`define TCC_BIT_START_EDGE     3
`define TCC_RANGE_HI           2
`define TCC_RANGE_LO           1
`define TCC_BIT_BEGIN          0

// Field positions in the second config register.
`define TCC_SPAN_HI            7
`define TCC_SPAN_LO            6
`define TCC_AVG_HI             5
`define TCC_AVG_LO             3
`define TCC_STOPS_HI           2
`define TCC_STOPS_LO           0

// Range codes.
`define TCC_RANGE_SHORT        2'h0
`define TCC_RANGE_LONG         2'h1

// Stop code limit and the single stop value.
`define TCC_STOPS_MAX_CODE     3'h4
`define TCC_STOPS_ONE          3'h1

// Calibration spans in clock periods.
`define TCC_SPAN_0             6'h02
`define TCC_SPAN_1             6'h0a
`define TCC_SPAN_2             6'h14
`define TCC_SPAN_3             6'h28

// Launch pulse width in clock cycles.
`define TCC_LAUNCH_CYCLES      4'h2
`endif

// [hdl/tcc_parity.v]
`timescale 1ns/1ps
// Forces the top bit of a result word so the whole word has even parity.
module tcc_parity #(
  parameter W = 24
) (
  // Data.
  input  wire [W-1:0] data_in,
  input  wire         enable_in,
  output wire [W-1:0] data_out
);
  // Parity bit is zero when disabled, else the xor of the payload bits.
  assign data_out = {enable_in & (^data_in[W-2:0]), data_in[W-2:0]};
endmodule

// [sim/tcc_cfg_props.sv]
`timescale 1ns/1ps
// Watches the register writes and the run handshake at the block's ports.
module tcc_cfg_props #(parameter RES_W = 24, parameter N_RES = 13) (
  // Clock, reset and register access.
  input wire clk_in, sys_rst_in, wr_en_in,
  input wire [5:0] addr_in,
  input wire [7:0] wdata_in,
  // Pins and core handshake.
  input wire start_pin_in, stop_pin_in, meas_done_in, meas_abort_in,
  input wire cal_done_in, launch_pulse_out, start_event_out, stop_event_out,
  input wire cal_run_out, status_clear_out, busy_out,
  input wire [1:0] timing_range_select_out,
  input wire [N_RES*RES_W-1:0] result_out
);
  reg  [7:0] cfg;
  wire       go;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // A write of the begin bit while idle launches a run.
  assign go = wr_en_in && addr_in == 6'h00 && wdata_in[0] && !busy_out;
  // Shadow of the first config register.
  always @(posedge clk_in)
    if (sys_rst_in) cfg <= 8'h00;
    else if (wr_en_in && addr_in == 6'h00) cfg <= wdata_in;
  property p_go;
    go |=> status_clear_out && busy_out ##1 result_out == '0;
  endproperty
  a_go: assert property (p_go) else $error("begin side effects");
  property p_launch;
    go |=> (launch_pulse_out == cfg[5])
      ##1 (launch_pulse_out != cfg[5]) [*2]
      ##1 (launch_pulse_out == cfg[5]);
  endproperty
  a_launch: assert property (p_launch) else $error("launch pulse");
  property p_cal;
    meas_done_in && busy_out |=> cal_run_out;
  endproperty
  a_cal: assert property (p_cal) else $error("no calibration");
  property p_abort;
    meas_abort_in && !meas_done_in && busy_out |=> cal_run_out == cfg[7];
  endproperty
  a_abort: assert property (p_abort) else $error("abort cal");
  property p_parity;
    result_out[RES_W-1] ==
      ($past(cfg[6]) ? ^result_out[RES_W-2:0] : 1'b0);
  endproperty
  a_parity: assert property (p_parity) else $error("parity");
  property p_start;
    busy_out && (cfg[3] ? $fell(start_pin_in) : $rose(start_pin_in))
      |-> ##[1:2] start_event_out;
  endproperty
  a_start: assert property (p_start) else $error("start edge");
  property p_stop;
    busy_out && (cfg[4] ? $fell(stop_pin_in) : $rose(stop_pin_in))
      |-> ##[1:2] stop_event_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop edge");
  property p_end;
    cal_done_in && busy_out |=> !busy_out;
  endproperty
  a_end: assert property (p_end) else $error("run not ended");
  property p_range;
    wr_en_in && addr_in == 6'h00 ##1 !wr_en_in
      |=> timing_range_select_out == ((cfg[2:1] == 2'h1) ? 2'h1 : 2'h0);
  endproperty
  a_range: assert property (p_range) else $error("range");
  c_go: cover property (go);
  c_abort: cover property (meas_abort_in && busy_out);
  c_end: cover property (cal_done_in && busy_out);
endmodule
bind tcc_config_control tcc_cfg_props #(.RES_W(RES_W), .N_RES(N_RES))
  chk_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_en_in(wr_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in),
    .start_pin_in(start_pin_in), .stop_pin_in(stop_pin_in),
    .meas_done_in(meas_done_in), .meas_abort_in(meas_abort_in),
    .cal_done_in(cal_done_in), .launch_pulse_out(launch_pulse_out),
    .start_event_out(start_event_out), .stop_event_out(stop_event_out),
    .cal_run_out(cal_run_out), .status_clear_out(status_clear_out),
    .busy_out(busy_out),
    .timing_range_select_out(timing_range_select_out),
    .result_out(result_out));

// [sim/tcc_host_model.sv]
`timescale 1ns/1ps
// Host side reaching the registers one word at a time.
module tcc_host_model (
  // Clock and read data.
  input  wire        clk_in,
  input  wire  [7:0] rdata_in,
  // Register access.
  output logic       wr_en_out,
  output logic [5:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    wr_en_out = 1'b0;
    addr_out = 6'h00;
    wdata_out = 8'h00;
  end
  // One-cycle strobe; data is scrambled after release so stale data shows.
  task wr(input [5:0] a, input [7:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // Read data is registered, so it is taken one edge after the address.
  task rd(input [5:0] a, output [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk_in = 0, sys_rst_in = 1, start_pin_in = 0, stop_pin_in = 0;
  logic meas_done_in = 0, meas_abort_in = 0, cal_done_in = 0;
  logic raw_valid_in = 0;
  logic [311:0] raw_result_in = '0;
  wire wr_en_in, launch_pulse_out, start_event_out, stop_event_out;
  wire cal_run_out, status_clear_out, busy_out;
  wire [5:0] addr_in, second_cal_span_out;
  wire [7:0] wdata_in, rdata_out, averaging_count_out;
  wire [1:0] timing_range_select_out;
  wire [2:0] stop_count_out;
  wire [311:0] result_out;
  integer fails = 0, total_checks = 0, cyc = 0, i;
  logic [7:0] v;
  logic [5:0] spans [4] = '{6'h02, 6'h0a, 6'h14, 6'h28};
  tcc_config_control dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_en_in(wr_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .start_pin_in(start_pin_in), .stop_pin_in(stop_pin_in),
    .launch_pulse_out(launch_pulse_out), .meas_done_in(meas_done_in),
    .meas_abort_in(meas_abort_in), .cal_done_in(cal_done_in),
    .raw_result_in(raw_result_in), .raw_valid_in(raw_valid_in),
    .start_event_out(start_event_out), .stop_event_out(stop_event_out),
    .cal_run_out(cal_run_out), .status_clear_out(status_clear_out),
    .timing_range_select_out(timing_range_select_out),
    .second_cal_span_out(second_cal_span_out),
    .averaging_count_out(averaging_count_out),
    .stop_count_out(stop_count_out), .busy_out(busy_out),
    .result_out(result_out));
  tcc_host_model host_u (.clk_in(clk_in), .rdata_in(rdata_out),
    .wr_en_out(wr_en_in), .addr_out(addr_in), .wdata_out(wdata_in));
  // Clock and hang guard.
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      results;
    end
  end
  task chk(input [8*8:1] nm, input [23:0] e, input [23:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %0s exp %h got %h", nm, e, g);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One run: idle pins, begin, edges, results, end of run, calibration.
  task run(input [7:0] c, input ab);
    @(posedge clk_in);
    start_pin_in <= c[3];
    stop_pin_in <= c[4];
    host_u.wr(6'h00, c);
    #1 chk("busy", 1'b1, busy_out);
    chk("clear", 1'b1, status_clear_out);
    chk("idle", c[5], launch_pulse_out);
    @(posedge clk_in);
    start_pin_in <= !c[3];
    // Stored results are cleared on the write edge and shown one edge later.
    #1 chk("zeroed", 24'h0, result_out[23:0]);
    chk("launch", !c[5], launch_pulse_out);
    @(posedge clk_in);
    #1 chk("start", 1'b1, start_event_out);
    repeat (2) @(posedge clk_in);
    stop_pin_in <= !c[4];
    raw_valid_in <= 1'b1;
    raw_result_in <= {13{24'h000001}};
    @(posedge clk_in);
    raw_valid_in <= 1'b0;
    meas_abort_in <= ab;
    meas_done_in <= !ab;
    #1 chk("stop", 1'b1, stop_event_out);
    @(posedge clk_in);
    meas_abort_in <= 1'b0;
    meas_done_in <= 1'b0;
    #1 chk("cal_run", ab ? c[7] : 1'b1, cal_run_out);
    chk("parity", c[6] ? 24'h800001 : 24'h1, result_out[23:0]);
    @(posedge clk_in);
    cal_done_in <= 1'b1;
    @(posedge clk_in);
    cal_done_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    host_u.rd(6'h00, v);
    chk("begin", c & 8'hfe, v);
    chk("range", (c[2:1] == 2'h1) ? 2'h1 : 2'h0, timing_range_select_out);
    $display("test run %h done", c);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    host_u.rd(6'h00, v);
    chk("cfg1", 8'h00, v);
    host_u.rd(6'h01, v);
    chk("cfg2", 8'h40, v);
    host_u.rd(6'h02, v);
    chk("unmapped", 8'h00, v);
    chk("span", 6'h0a, second_cal_span_out);
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) begin
      host_u.wr(6'h01, {i[1:0], i[2:0], i[2:0]});
      repeat (2) @(posedge clk_in);
      #1 chk("span", spans[i[1:0]], second_cal_span_out);
      chk("avg", 8'h01 << i, averaging_count_out);
      chk("stops", (i < 5) ? i[2:0] + 3'h1 : 3'h1, stop_count_out);
      host_u.rd(6'h01, v);
      chk("cfg2", {i[1:0], i[2:0], i[2:0]}, v);
    end
    $display("test config second done");
    run(8'h41, 1'b0);
    run(8'hbb, 1'b1);
    run(8'h03, 1'b1);
    results;
  end
endmodule
